// ==== rtl/lwe_pkg.sv ====
// Shared constants and types of the word-load execution unit.
// Assumes instruction bit 31 is the most significant (big-end bit 0).
`default_nettype none
package lwe_pkg;
  // Major opcodes of the register and immediate forms
  localparam logic [5:0] OP_REG = 6'h32;
  localparam logic [5:0] OP_IMM = 6'h3A;
  // Function field, instruction bits 10..0
  localparam logic [10:0] FN_EXCL = 11'h400;
  localparam logic [10:0] FN_ZERO_MASK = 11'h57F;
  localparam int FN_R_BIT = 9;
  localparam int FN_EA_BIT = 7;
  // Exception causes
  localparam logic [4:0] EC_TLB = 5'h12;
  localparam logic [4:0] EC_ZONE = 5'h10;
  localparam logic [4:0] EC_ALIGN = 5'h01;
  localparam logic [4:0] EC_BUS = 5'h04;
  localparam logic [4:0] EC_PRIV = 5'h07;
  // Bus response code for a granted exclusive read
  localparam logic [1:0] RESP_EXOKAY = 2'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_HOLD = 5'h04,
    ST_ADDR = 5'h08,
    ST_DATA = 5'h10
  } lwe_state_t;

  typedef struct packed {
    logic valid;
    logic excl;
    logic imm;
    logic rev;
    logic ea;
    logic [4:0] rd;
    logic [15:0] imm16;
  } lwe_dec_t;

  typedef struct packed {
    logic um;
    logic vm;
    logic saved_user_mode;
    logic saved_virtual_mode;
  } lwe_mode_t;

  typedef struct packed {
    logic [4:0] cause;
    logic s;
    logic w;
    logic [4:0] rx;
    logic zone_fault_flag;
    logic ecc;
  } lwe_esr_t;
endpackage
`default_nettype wire

// ==== rtl/lwe_decode.sv ====
// Instruction decoder for the three word-load forms.
// Assumes the instruction word is stable while it is examined.
`timescale 1ns/10ps
`default_nettype none
module lwe_decode #(
  parameter int REORDER_EN = 1,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input wire logic [31:0] instr,
  output lwe_pkg::lwe_dec_t dec
);
  // Opcode and function field split into a decoded record
  always_comb begin
    dec = '0;
    dec.rd = instr[25:21];
    dec.imm16 = instr[15:0];
    case (instr[31:26])
      lwe_pkg::OP_REG: begin
        if (instr[10:0] == lwe_pkg::FN_EXCL) begin
          dec.excl = 1'b1;
          dec.valid = 1'b1;
        end else if ((instr[10:0] & lwe_pkg::FN_ZERO_MASK) == 11'h000) begin
          dec.rev = instr[lwe_pkg::FN_R_BIT];
          dec.ea = instr[lwe_pkg::FN_EA_BIT];
          // Reserved combinations and unsupported variants stay invalid
          dec.valid = !(dec.rev && dec.ea)
            && (!dec.rev || REORDER_EN == 1)
            && (!dec.ea || (ADDR_W > 32 && DATA_W == 32));
        end
      end
      lwe_pkg::OP_IMM: begin
        dec.imm = 1'b1;
        dec.valid = 1'b1;
      end
      default: begin
        dec.valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/lwe_agen.sv ====
// Address former for the word loads.
// Assumes ADDR_W lies between 32 and 64.
`timescale 1ns/10ps
`default_nettype none
module lwe_agen #(
  parameter int ADDR_W = 32
) (
  input wire lwe_pkg::lwe_dec_t dec,
  input wire logic [31:0] base,
  input wire logic [31:0] index,
  input wire logic pfx_valid,
  input wire logic [15:0] pfx_hi,
  output logic [ADDR_W-1:0] addr
);
  logic [31:0] opnd;
  logic [31:0] sum;

  // Second operand: index register or extended immediate
  always_comb begin
    if (!dec.imm) begin
      opnd = index;
    end else if (pfx_valid) begin
      opnd = {pfx_hi, dec.imm16};
    end else begin
      opnd = {{16{dec.imm16[15]}}, dec.imm16};
    end
    sum = base + opnd;
  end

  // Extended form concatenates base and index
  generate
    if (ADDR_W > 32) begin : g_wide
      assign addr = dec.ea ? {base[ADDR_W-33:0], index}
                           : {{(ADDR_W-32){1'b0}}, sum};
    end else begin : g_narrow
      assign addr = sum[ADDR_W-1:0];
    end
  endgenerate
endmodule
`default_nettype wire

// ==== rtl/lwe_core.sv ====
// Word-load execution unit: decode, address, checks, bus read, write-back.
// Assumes MMU lookups answer for lookup_addr in the same cycle and a
// single-beat 32-bit read channel toward the data interconnect.
`timescale 1ns/10ps
`default_nettype none
module lwe_core #(
  parameter int AREA_OPT = 0,
  parameter int REORDER_EN = 1,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter bit PERIPH_EXCL = 1'b1,
  parameter bit CACHE_EXCL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [31:0] instr,
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_val,
  input wire logic imm_pfx_valid,
  input wire logic [15:0] imm_pfx_hi,
  input wire lwe_pkg::lwe_mode_t mode_in,
  input wire logic exc_enable,
  input wire logic pae_enable,
  input wire logic ea_allowed,
  output logic [ADDR_W-1:0] lookup_addr,
  input wire logic tlb_miss,
  input wire logic zone_no_access,
  input wire logic addr_cached,
  output logic m_arvalid,
  input wire logic m_arready,
  output logic [ADDR_W-1:0] m_araddr,
  output logic m_arlock,
  input wire logic m_rvalid,
  output logic m_rready,
  input wire logic [31:0] m_rdata,
  input wire logic [1:0] m_rresp,
  output logic illegal,
  output logic done,
  output logic rd_we,
  output logic [4:0] rd_idx,
  output logic [DATA_W-1:0] rd_data,
  output logic exc_valid,
  output lwe_pkg::lwe_esr_t exception_status,
  output logic mode_we,
  output lwe_pkg::lwe_mode_t mode_out,
  output logic carry_we,
  output logic carry,
  output logic resv_set
);
  lwe_pkg::lwe_state_t state_r;
  lwe_pkg::lwe_state_t state_nxt;
  lwe_pkg::lwe_dec_t dec;
  lwe_pkg::lwe_dec_t dec_r;
  lwe_pkg::lwe_esr_t exc_esr;
  lwe_pkg::lwe_esr_t bus_esr;
  lwe_pkg::lwe_mode_t saved_mode;
  logic [ADDR_W-1:0] addr;
  logic issue_fire;
  logic eval;
  logic exc_hit;
  logic exc_mode;
  logic priv_err;
  logic excl_on;
  logic excl_on_r;
  logic r_fire;
  logic nok;
  logic [31:0] load_word;

  lwe_decode #(
    .REORDER_EN(REORDER_EN),
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) i_lwe_decode (
    .instr(instr),
    .dec(dec)
  );

  lwe_agen #(
    .ADDR_W(ADDR_W)
  ) i_lwe_agen (
    .dec(dec),
    .base(base_val),
    .index(index_val),
    .pfx_valid(imm_pfx_valid),
    .pfx_hi(imm_pfx_hi),
    .addr(addr)
  );

  // Byte order swap of a loaded word
  function automatic logic [31:0] bswap(input logic [31:0] w);
    bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Handshake terms and the cycle in which checks resolve
  assign issue_fire = issue_valid && issue_ready;
  assign eval = (state_r == lwe_pkg::ST_CHECK && AREA_OPT != 1)
             || state_r == lwe_pkg::ST_HOLD;
  assign r_fire = m_rvalid && m_rready;
  assign excl_on = addr_cached ? CACHE_EXCL : PERIPH_EXCL;
  assign nok = excl_on_r && (m_rresp != lwe_pkg::RESP_EXOKAY);
  assign priv_err = dec_r.ea && pae_enable && !ea_allowed;
  assign load_word = dec_r.rev ? bswap(m_rdata) : m_rdata;
  assign saved_mode = '{um: 1'b0, vm: 1'b0, saved_user_mode: mode_in.um, saved_virtual_mode: mode_in.vm};

  // Prioritised exception selection at the check cycle
  always_comb begin
    exc_esr = '0;
    exc_hit = 1'b1;
    exc_mode = 1'b0;
    if (priv_err) begin
      exc_esr.cause = lwe_pkg::EC_PRIV;
    end else if (mode_in.vm && tlb_miss) begin
      exc_esr.cause = lwe_pkg::EC_TLB;
      exc_mode = 1'b1;
    end else if (mode_in.um && mode_in.vm && zone_no_access) begin
      exc_esr.cause = lwe_pkg::EC_ZONE;
      exc_esr.zone_fault_flag = 1'b1;
      exc_mode = 1'b1;
    end else if (!dec_r.excl && lookup_addr[1:0] != 2'h0) begin
      exc_esr.cause = lwe_pkg::EC_ALIGN;
      exc_esr.w = 1'b1;
      exc_esr.rx = dec_r.rd;
    end else begin
      exc_hit = 1'b0;
    end
  end

  // Data bus exception record for a refused exclusive read
  always_comb begin
    bus_esr = '0;
    bus_esr.cause = lwe_pkg::EC_BUS;
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lwe_pkg::ST_IDLE: begin
        if (issue_fire && dec.valid) begin
          state_nxt = lwe_pkg::ST_CHECK;
        end
      end
      lwe_pkg::ST_CHECK: begin
        if (AREA_OPT == 1) begin
          state_nxt = lwe_pkg::ST_HOLD;
        end else begin
          state_nxt = exc_hit ? lwe_pkg::ST_IDLE : lwe_pkg::ST_ADDR;
        end
      end
      lwe_pkg::ST_HOLD: begin
        state_nxt = exc_hit ? lwe_pkg::ST_IDLE : lwe_pkg::ST_ADDR;
      end
      lwe_pkg::ST_ADDR: begin
        if (m_arready) begin
          state_nxt = lwe_pkg::ST_DATA;
        end
      end
      lwe_pkg::ST_DATA: begin
        if (m_rvalid) begin
          state_nxt = lwe_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = lwe_pkg::ST_IDLE;
      end
    endcase
  end

  // State register and issue acceptance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= lwe_pkg::ST_IDLE;
      issue_ready <= 1'b0;
    end else begin
      state_r <= state_nxt;
      issue_ready <= (state_nxt == lwe_pkg::ST_IDLE);
    end
  end

  // Capture of the accepted instruction and its address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_r <= '0;
      lookup_addr <= '0;
      illegal <= 1'b0;
    end else begin
      illegal <= issue_fire && !dec.valid;
      if (issue_fire && dec.valid) begin
        dec_r <= dec;
        lookup_addr <= addr;
      end
    end
  end

  // Read address and data channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      m_arvalid <= 1'b0;
      m_araddr <= '0;
      m_arlock <= 1'b0;
      m_rready <= 1'b0;
      excl_on_r <= 1'b0;
    end else begin
      if (eval && !exc_hit) begin
        m_arvalid <= 1'b1;
        m_araddr <= lookup_addr;
        m_arlock <= dec_r.excl && excl_on;
        excl_on_r <= dec_r.excl && excl_on;
      end else if (m_arvalid && m_arready) begin
        m_arvalid <= 1'b0;
      end
      if (m_arvalid && m_arready) begin
        m_rready <= 1'b1;
      end else if (r_fire) begin
        m_rready <= 1'b0;
      end
    end
  end

  // Write-back, status and mode updates
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      rd_we <= 1'b0;
      rd_idx <= '0;
      rd_data <= '0;
      exc_valid <= 1'b0;
      exception_status <= '0;
      mode_we <= 1'b0;
      mode_out <= '0;
      carry_we <= 1'b0;
      carry <= 1'b0;
      resv_set <= 1'b0;
    end else begin
      done <= 1'b0;
      rd_we <= 1'b0;
      exc_valid <= 1'b0;
      mode_we <= 1'b0;
      carry_we <= 1'b0;
      resv_set <= 1'b0;
      if (eval && exc_hit) begin
        done <= 1'b1;
        exc_valid <= 1'b1;
        exception_status <= exc_esr;
        mode_we <= exc_mode;
        mode_out <= saved_mode;
      end else if (r_fire) begin
        done <= 1'b1;
        if (dec_r.excl && nok && exc_enable) begin
          exc_valid <= 1'b1;
          exception_status <= bus_esr;
          mode_we <= 1'b1;
          mode_out <= saved_mode;
        end else begin
          rd_we <= 1'b1;
          rd_idx <= dec_r.rd;
          rd_data <= DATA_W'(load_word);
          if (dec_r.excl) begin
            resv_set <= 1'b1;
            carry_we <= 1'b1;
            carry <= nok;
          end
        end
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_issue;
    issue_fire && dec.valid;
  endsequence

  sequence s_excl_beat;
    r_fire && dec_r.excl;
  endsequence

  a_no_rd_exc: assert property (exc_valid |-> !rd_we && !carry_we)
    else $error("destination or carry written with exception");
  a_fast_latency: assert property ((AREA_OPT != 1) and s_issue
    |=> eval ##1 state_r != lwe_pkg::ST_CHECK)
    else $error("check phase not one cycle");
  a_area_latency: assert property ((AREA_OPT == 1) and s_issue
    |=> !eval ##1 eval)
    else $error("check phase not two cycles");
  a_tlb_first: assert property (eval && !priv_err && mode_in.vm && tlb_miss
    |=> exc_valid && exception_status.cause == lwe_pkg::EC_TLB && mode_we && !mode_out.vm)
    else $error("TLB miss not reported first");
  a_zone_fault: assert property (eval && !priv_err && !tlb_miss
    && mode_in.um && mode_in.vm && zone_no_access
    |=> exc_valid && exception_status.cause == lwe_pkg::EC_ZONE && exception_status.zone_fault_flag && mode_out.saved_user_mode)
    else $error("zone fault not reported");
  a_align_word: assert property (eval && exc_hit
    && exc_esr.cause == lwe_pkg::EC_ALIGN
    |=> exc_valid && exception_status.w && exception_status.rx == dec_r.rd && !mode_we)
    else $error("misalignment record wrong");
  a_excl_align: assert property (exc_valid && dec_r.excl
    |-> exception_status.cause != lwe_pkg::EC_ALIGN)
    else $error("exclusive load raised misalignment");
  a_carry_value: assert property (s_excl_beat and !(nok && exc_enable)
    |=> carry_we && resv_set && carry == $past(nok))
    else $error("carry or reservation wrong after exclusive load");
  a_bus_exc: assert property (s_excl_beat and (nok && exc_enable)
    |=> exc_valid && exception_status.cause == lwe_pkg::EC_BUS && !exception_status.ecc && !resv_set)
    else $error("bus exception missing");
  a_excl_lock: assert property (m_arvalid && dec_r.excl && excl_on_r |-> m_arlock)
    else $error("exclusive read not locked");
  a_zero_upper: assert property (rd_we |-> (rd_data >> 32) == '0)
    else $error("upper destination bits not cleared");
endmodule
`default_nettype wire

// ==== tb/lwe_axi_slave.sv ====
// AXI read slave standing in for the data interconnect and its slaves.
// Assumes single-beat reads with one request outstanding at a time.
`timescale 1ns/10ps
`default_nettype none
module lwe_axi_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire logic excl_ok,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic arlock,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic [31:0] last_addr,
  output logic last_lock
);
  logic pend_r;
  logic [1:0] cnt_r;
  // Address accept after lat cycles, then one beat held until taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      pend_r <= 1'b0;
      cnt_r <= 2'h0;
      rdata <= 32'h0;
      rresp <= 2'h0;
      last_addr <= 32'h0;
      last_lock <= 1'b0;
    end else begin
      arready <= 1'b0;
      cnt_r <= cnt_r + 2'h1;
      if (arvalid && arready) begin
        pend_r <= 1'b1;
        last_addr <= araddr;
        last_lock <= arlock;
        cnt_r <= 2'h0;
      end else if (arvalid && !pend_r && cnt_r >= lat) begin
        arready <= 1'b1;
      end
      if (pend_r && !rvalid && cnt_r >= lat) begin
        rvalid <= 1'b1;
        rdata <= {last_addr[31:2], 2'h0} ^ 32'hC3A5_5A3C;
        rresp <= (last_lock && excl_ok) ? 2'h1 : 2'h0;
      end
      // Released data lines show the inverse so stale values never match
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        pend_r <= 1'b0;
        rdata <= ~rdata;
        rresp <= ~rresp;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_load_word_execution.sv ====
// Self-checking bench for the word-load unit against a model AXI slave.
// Assumes default parameters: 32-bit address and data, peripheral exclusive on.
`timescale 1ns/10ps
`default_nettype none
module tb_load_word_execution;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue_valid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [31:0] base_val = 32'h0;
  logic [31:0] index_val = 32'h0;
  logic imm_pfx_valid = 1'b0;
  logic [15:0] imm_pfx_hi = 16'h0;
  lwe_pkg::lwe_mode_t mode_in = '0;
  logic exc_enable = 1'b0;
  logic tlb_miss = 1'b0;
  logic zone_no_access = 1'b0;
  logic addr_cached = 1'b0;
  logic excl_ok = 1'b1;
  logic [1:0] lat = 2'h0;
  logic issue_ready, m_arvalid, m_arready, m_arlock, m_rvalid, m_rready;
  logic illegal, done, rd_we, exc_valid, mode_we, carry_we, carry, resv_set, sl_lock;
  logic [31:0] m_araddr, m_rdata, rd_data, sl_addr;
  logic [1:0] m_rresp;
  logic [4:0] rd_idx;
  lwe_pkg::lwe_esr_t exception_status;
  lwe_pkg::lwe_mode_t mode_out;
  int mismatches = 0;
  int n_tests = 0;
  int waited;
  // Clock at 10 MHz
  always #50 clk = ~clk;
  lwe_core i_lwe_core (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .instr(instr), .base_val(base_val), .index_val(index_val),
    .imm_pfx_valid(imm_pfx_valid), .imm_pfx_hi(imm_pfx_hi), .mode_in(mode_in),
    .exc_enable(exc_enable), .pae_enable(1'b0), .ea_allowed(1'b0), .lookup_addr(),
    .tlb_miss(tlb_miss), .zone_no_access(zone_no_access), .addr_cached(addr_cached),
    .m_arvalid(m_arvalid), .m_arready(m_arready), .m_araddr(m_araddr), .m_arlock(m_arlock),
    .m_rvalid(m_rvalid), .m_rready(m_rready), .m_rdata(m_rdata), .m_rresp(m_rresp),
    .illegal(illegal), .done(done), .rd_we(rd_we), .rd_idx(rd_idx), .rd_data(rd_data),
    .exc_valid(exc_valid), .exception_status(exception_status), .mode_we(mode_we), .mode_out(mode_out),
    .carry_we(carry_we), .carry(carry), .resv_set(resv_set));
  lwe_axi_slave i_lwe_axi_slave (.clk(clk), .rst_n(rst_n), .lat(lat), .excl_ok(excl_ok),
    .arvalid(m_arvalid), .arready(m_arready), .araddr(m_araddr), .arlock(m_arlock),
    .rvalid(m_rvalid), .rready(m_rready), .rdata(m_rdata), .rresp(m_rresp),
    .last_addr(sl_addr), .last_lock(sl_lock));
  // Comparison and verdict
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'hC3A5_5A3C;
  endfunction
  function automatic logic [31:0] rins(input logic [4:0] rd, input logic [10:0] fn);
    return {lwe_pkg::OP_REG, rd, 5'h03, 5'h04, fn};
  endfunction
  // One issue; cfg is {exc_enable, excl_ok, lat}, mmu is {tlb, zone, cached}
  task automatic go(input logic [31:0] ins, input logic [31:0] b, input logic [31:0] x,
    input logic [2:0] mmu, input logic [3:0] md, input logic [3:0] cfg, input logic [16:0] pfx);
    waited = 0;
    while (issue_ready !== 1'b1 && waited < 20) begin
      @(posedge clk);
      #1 waited++;
    end
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= ins;
    base_val <= b;
    index_val <= x;
    {tlb_miss, zone_no_access, addr_cached} <= mmu;
    mode_in <= md;
    {exc_enable, excl_ok, lat} <= cfg;
    {imm_pfx_valid, imm_pfx_hi} <= pfx;
    @(posedge clk);
    issue_valid <= 1'b0;
    waited = 0;
    // Illegal answers on the take edge itself, so look before the next edge
    #1;
    while (done !== 1'b1 && illegal !== 1'b1 && waited < 30) begin
      @(posedge clk);
      #1 waited++;
    end
    if (waited >= 30) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic t_indexed();
    go(rins(5'h05, 11'h000), 32'h1000_0F00, 32'h0000_0104, 3'h0, 4'h0, 4'h6, 17'h0);
    chk(rd_we & ~exc_valid, 1);
    chk(rd_idx, 5'h05);
    chk(rd_data, mem(32'h1000_1004));
    chk({sl_addr, sl_lock}, {32'h1000_1004, 1'b0});
    go(rins(5'h06, 11'h200), 32'h0000_2000, 32'h0000_0010, 3'h0, 4'h0, 4'h4, 17'h0);
    chk(rd_data, {<<8{mem(32'h0000_2010)}});
  endtask
  task automatic t_imm();
    go({lwe_pkg::OP_IMM, 5'h07, 5'h03, 16'hFFFC}, 32'h2000, 0, 3'h0, 4'h0, 4'h4, 17'h0);
    chk(sl_addr, 32'h0000_1FFC);
    chk(rd_data, mem(32'h0000_1FFC));
    go({lwe_pkg::OP_IMM, 5'h07, 5'h03, 16'h8010}, 32'h100, 0, 3'h0, 4'h0, 4'h4, 17'h1_0001);
    chk(sl_addr, 32'h0001_8110);
  endtask
  task automatic t_faults();
    go(rins(5'h09, 11'h000), 32'h300, 32'h2, 3'h0, 4'hC, 4'h4, 17'h0);
    chk(exception_status, {lwe_pkg::EC_ALIGN, 1'b0, 1'b1, 5'h09, 2'h0});
    chk({exc_valid, rd_we, mode_we}, 3'h4);
    chk(waited, 1);
    go(rins(5'h09, 11'h000), 32'h300, 32'h2, 3'h6, 4'hC, 4'h4, 17'h0);
    chk(exception_status.cause, lwe_pkg::EC_TLB);
    chk({mode_we, mode_out, exception_status.s, rd_we}, {1'b1, 4'h3, 2'h0});
    go(rins(5'h09, 11'h000), 32'h300, 32'h1, 3'h2, 4'hC, 4'h4, 17'h0);
    chk({exception_status.cause, exception_status.s, exception_status.zone_fault_flag}, {lwe_pkg::EC_ZONE, 2'h1});
    chk({exc_valid, mode_we, mode_out, rd_we}, {2'h3, 4'h3, 1'b0});
    go(rins(5'h09, 11'h000), 32'h300, 32'h0, 3'h2, 4'h4, 4'h4, 17'h0);
    chk({rd_we, exc_valid}, 2'h2);
  endtask
  task automatic t_excl();
    go(rins(5'h0A, lwe_pkg::FN_EXCL), 32'h400, 32'h3, 3'h0, 4'h0, 4'h4, 17'h0);
    chk({rd_we, resv_set, carry_we, carry, exc_valid}, 5'h1C);
    chk({rd_data, sl_lock}, {mem(32'h403), 1'b1});
    go(rins(5'h0A, lwe_pkg::FN_EXCL), 32'h400, 32'h0, 3'h0, 4'h0, 4'h0, 17'h0);
    chk({rd_we, carry_we, carry}, 3'h7);
    go(rins(5'h0A, lwe_pkg::FN_EXCL), 32'h400, 32'h0, 3'h1, 4'h0, 4'h0, 17'h0);
    chk({rd_we, carry_we, carry}, 3'h6);
    go(rins(5'h0A, lwe_pkg::FN_EXCL), 32'h400, 32'h0, 3'h0, 4'h8, 4'h8, 17'h0);
    chk({exception_status.cause, exception_status.ecc, mode_out}, {lwe_pkg::EC_BUS, 1'b0, 4'h2});
    chk({exc_valid, mode_we, rd_we, carry_we}, 4'hC);
  endtask
  task automatic t_illegal();
    logic [10:0] fns [3];
    fns = '{11'h001, 11'h080, 11'h280};
    foreach (fns[i]) begin
      go(rins(5'h0B, fns[i]), 32'h500, 32'h0, 3'h0, 4'h0, 4'h4, 17'h0);
      chk({illegal, done, rd_we}, 3'h4);
    end
  endtask
  // Reset for 16 cycles, then every scenario in turn
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_indexed();
    t_imm();
    t_faults();
    t_excl();
    t_illegal();
    tally_and_finish();
  end
endmodule
`default_nettype wire
